//--- dv/test_iap_flash_program_controller.sv
// self-checking testbench of the in-application flash controller
`timescale 1ns/100ps
`default_nettype none
module test_iap_flash_program_controller;
  import iapfc_pkg::*;

  localparam logic [15:0] PAT [3] = '{16'h1234, 16'h5678, 16'h9abc};
  localparam int          UNLK    = 8;

  logic        clk_sys;
  logic        reset_n;
  logic [2:0]  sfr_sector;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata_r;
  logic        fl_req_r;
  logic [1:0]  fl_op_r;
  logic [13:0] fl_addr_r;
  logic [15:0] fl_wdata_r;
  logic        fl_done;
  logic [15:0] fl_rdata;
  logic        cpu_stall_r;
  logic        chip_reset_r;
  logic [13:0] req_addr [128];
  logic [15:0] req_data [128];
  logic [1:0]  req_op   [128];
  logic        req_stall[128];
  int          n_req;
  int          failures;
  int          tests_run;
  logic [7:0]  rv;

  iapfc_ctrl #(.UNLOCK_CYCLES(UNLK), .UNLOCK_PAT1(PAT[0]),
               .UNLOCK_PAT2(PAT[1]), .UNLOCK_PAT3(PAT[2])) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .sfr_sector(sfr_sector),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .fl_req_r(fl_req_r), .fl_op_r(fl_op_r), .fl_addr_r(fl_addr_r),
    .fl_wdata_r(fl_wdata_r), .fl_done(fl_done), .fl_rdata(fl_rdata),
    .cpu_stall_r(cpu_stall_r), .chip_reset_r(chip_reset_r));

  always #12.5 clk_sys = ~clk_sys;

  // flash macro stand-in: logs each command, answers two cycles later
  // read data is only meaningful with done, so it is inverted otherwise
  always @(posedge clk_sys) begin
    if (fl_req_r === 1'b1) begin
      req_addr[n_req]  = fl_addr_r;
      req_data[n_req]  = fl_wdata_r;
      req_op[n_req]    = fl_op_r;
      req_stall[n_req] = cpu_stall_r;
      n_req++;
      repeat (2) @(posedge clk_sys);
      #2 fl_done = 1'b1;
      fl_rdata = 16'hbeef;
      @(posedge clk_sys);
      #2 fl_done = 1'b0;
      fl_rdata = 16'h4110;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #2 sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] s, input logic [7:0] a,
                    output logic [7:0] d);
    @(posedge clk_sys);
    #2 sfr_sector = s;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #2 sfr_rd = 1'b0;
    sfr_sector = 3'h1;
    d = sfr_rdata_r;
  endtask

  // the cpu is stalled during an operation, so no access until it ends
  task automatic idle();
    int i;
    // look a little after each edge so the stall flop has settled
    repeat (4) @(posedge clk_sys);
    #2;
    for (i = 0; i < 500 && cpu_stall_r !== 1'b0; i++) begin
      @(posedge clk_sys);
      #2;
    end
    check(cpu_stall_r, 1'b0);
  endtask

  task automatic t_reset_and_refused_load();
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'h00);
    wr(OFS_DW0_LO, 8'h11);
    wr(OFS_DW0_HI, 8'h22);
    rd(3'h1, OFS_ADDR_LO, rv);
    check(rv, 8'h00);
  endtask

  task automatic t_unlock();
    int i;
    for (i = 0; i < 3; i++) begin
      wr(8'h47 + 8'(2 * i), PAT[i][7:0]);
      wr(8'h48 + 8'(2 * i), PAT[i][15:8]);
    end
    wr(OFS_OP_CTRL, 8'he8);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'he8);
    rd(3'h0, OFS_OP_CTRL, rv);
    check(rv, 8'h00);
    repeat (UNLK + 2) @(posedge clk_sys);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'he0);
  endtask

  // loads near the page end: low byte holds, high byte steps, then sticks
  task automatic t_load_boundary();
    wr(OFS_ADDR_LO, 8'h7e);
    wr(OFS_ADDR_HI, 8'h02);
    wr(OFS_DW0_LO, 8'h11);
    rd(3'h1, OFS_ADDR_LO, rv);
    check(rv, 8'h7e);
    wr(OFS_DW0_HI, 8'h22);
    rd(3'h1, OFS_ADDR_LO, rv);
    check(rv, 8'h7f);
    wr(OFS_DW0_HI, 8'h33);
    rd(3'h1, OFS_ADDR_LO, rv);
    check(rv, 8'h7f);
    rd(3'h1, OFS_ADDR_HI, rv);
    check(rv, 8'h02);
  endtask

  task automatic t_reserved_mode();
    n_req = 0;
    wr(OFS_OP_CTRL, 8'ha4);
    repeat (6) @(posedge clk_sys);
    check(16'(n_req), 16'h0000);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'ha0);
  endtask

  task automatic t_erase();
    n_req = 0;
    wr(OFS_ADDR_LO, 8'h55);
    wr(OFS_ADDR_HI, 8'h00);
    wr(OFS_OP_CTRL, 8'h94);
    idle();
    check(16'(n_req), 16'h0001);
    check(req_op[0], FOP_ERASE);
    check(req_addr[0], 14'h0040);
    check(req_stall[0], 1'b1);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'h90);
  endtask

  task automatic t_program();
    n_req = 0;
    wr(OFS_BUF_CLR, 8'h01);
    rd(3'h1, OFS_BUF_CLR, rv);
    check(rv, 8'h00);
    wr(OFS_ADDR_LO, 8'h40);
    wr(OFS_DW0_LO, 8'h5a);
    wr(OFS_DW0_HI, 8'ha5);
    wr(OFS_DW0_LO, 8'h0f);
    wr(OFS_DW0_HI, 8'hf0);
    wr(OFS_ADDR_LO, 8'h40);
    wr(OFS_OP_CTRL, 8'h84);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'h84);
    idle();
    check(16'(n_req), 16'h0040);
    check(req_op[5], FOP_PROG);
    check(req_addr[0], 14'h0040);
    check(req_addr[63], 14'h007f);
    check(req_data[0], 16'ha55a);
    check(req_data[1], 16'hf00f);
    check(req_data[62], 16'h0000);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'h80);
    // two wrong loads, a manual clear, then only word 1 reloaded
    wr(OFS_ADDR_LO, 8'h41);
    wr(OFS_DW0_LO, 8'h66);
    wr(OFS_DW0_HI, 8'h77);
    wr(OFS_DW0_HI, 8'h77);
    wr(OFS_BUF_CLR, 8'h01);
    wr(OFS_ADDR_LO, 8'h41);
    wr(OFS_DW0_LO, 8'hc3);
    wr(OFS_DW0_HI, 8'h3c);
    wr(OFS_ADDR_LO, 8'h40);
    n_req = 0;
    wr(OFS_OP_CTRL, 8'h84);
    idle();
    check(req_data[0], 16'h0000);
    check(req_data[1], 16'h3cc3);
    check(req_data[2], 16'h0000);
  endtask

  task automatic t_read();
    n_req = 0;
    wr(OFS_ADDR_LO, 8'h95);
    wr(OFS_ADDR_HI, 8'h3f);
    wr(OFS_OP_CTRL, 8'hb2);
    wr(OFS_OP_CTRL, 8'hb3);
    idle();
    check(req_op[0], FOP_READ);
    check(req_addr[0], 14'h3f95);
    rd(3'h1, OFS_DW0_LO, rv);
    check(rv, 8'hef);
    rd(3'h1, OFS_DW0_HI, rv);
    check(rv, 8'hbe);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'hb2);
    // writing the flag bit low drops the erase/write enable
    wr(OFS_OP_CTRL, 8'h00);
    rd(3'h1, OFS_OP_CTRL, rv);
    check(rv, 8'h00);
  endtask

  task automatic t_chip_reset();
    wr(OFS_CHIP_RST, 8'h54);
    check(chip_reset_r, 1'b0);
    wr(OFS_CHIP_RST, CHIP_RESET_KEY);
    check(chip_reset_r, 1'b1);
    @(posedge clk_sys);
    #2 check(chip_reset_r, 1'b0);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end

  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    sfr_sector = 3'h1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    fl_done = 1'b0;
    fl_rdata = 16'h4110;
    n_req = 0;
    failures = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    t_reset_and_refused_load();
    t_unlock();
    t_load_boundary();
    t_reserved_mode();
    t_erase();
    t_program();
    t_read();
    t_chip_reset();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- hdl/iapfc_ctrl.sv
// in-application flash programming controller with its special registers
// Function
// - erase/write whole 64-word pages, read single words
// - successful unlock sets erase/write-enabled flag
// - buffer loads only while enabled flag high
// - write-initiate bit stays high until programming ends
// - read needs read-enable; initiate clears when data ready
// - page chosen by address bits 13..6
// - buffer holds 64 words for the current page
// - buffer-clear bit clears buffer, then returns low
// - high-byte write loads full word into buffer
// - each buffer load below the page's last word increments the address register
// - address sticks at last word of page
// - page write completion clears buffer automatically
// - registers live in data memory sector 1
// - three-bit mode field selects operation
// - unlock trigger runs timer, cleared on timeout
// - writing 55h to reset pattern resets chip
// - low-byte write only updates holding register
`timescale 1ns/100ps
`default_nettype none
module iapfc_ctrl
  import iapfc_pkg::*;
#(
  parameter int          UNLOCK_CYCLES = UNLOCK_CYC,
  parameter logic [15:0] UNLOCK_PAT1   = 16'h1234, // arbitrary value
  parameter logic [15:0] UNLOCK_PAT2   = 16'h5678, // arbitrary value
  parameter logic [15:0] UNLOCK_PAT3   = 16'h9abc  // arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [2:0]  sfr_sector,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata_r,
  output logic             fl_req_r,
  output logic      [1:0]  fl_op_r,
  output logic      [13:0] fl_addr_r,
  output logic      [15:0] fl_wdata_r,
  input  wire logic        fl_done,
  input  wire logic [15:0] fl_rdata,
  output logic             cpu_stall_r,
  output logic             chip_reset_r
);

  generate
    if (UNLOCK_CYCLES < 2 || UNLOCK_CYCLES > 65535) begin : g_chk
      $error("iapfc_ctrl: UNLOCK_CYCLES out of range 2..65535");
    end
  endgenerate

  // register decode, shared by the write and read paths
  function automatic logic sfr_hit(input logic [2:0] sect,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return (sect == IAP_SECTOR) && (addr == ofs);
  endfunction

  function automatic logic [7:0] dw_ofs(input int pair, input logic hi);
    return OFS_DW0_LO + 8'(2 * pair) + {7'h00, hi};
  endfunction

  // control fields
  logic              en_flag_r;
  logic [2:0]        mode_r;
  logic              trig_r;
  logic              wt_r;
  logic              rden_r;
  logic              rd_r;
  logic              buffer_clear_bit_r;
  logic [7:0]        rstpat_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        dlo_r [DPAIRS];
  logic [7:0]        dhi_r [DPAIRS];
  logic [15:0]       unl_cnt_r;
  logic [OFS_W-1:0]  pidx_r;

  iapfc_state_t state_r;
  iapfc_state_t state_nxt;

  logic wr_op, wr_rst, wr_clr, wr_alo, wr_ahi, wr_d0h;
  logic buf_we, buf_clr, unlock_ok, op_done, drop_wt, drop_rd;
  logic start_erase, start_prog, start_read, read_done;
  logic [WORD_W-1:0] buf_rd;

  assign wr_op  = sfr_wr && sfr_hit(sfr_sector, sfr_addr, OFS_OP_CTRL);
  assign wr_rst = sfr_wr && sfr_hit(sfr_sector, sfr_addr, OFS_CHIP_RST);
  assign wr_clr = sfr_wr && sfr_hit(sfr_sector, sfr_addr, OFS_BUF_CLR);
  assign wr_alo = sfr_wr && sfr_hit(sfr_sector, sfr_addr, OFS_ADDR_LO);
  assign wr_ahi = sfr_wr && sfr_hit(sfr_sector, sfr_addr, OFS_ADDR_HI);
  assign wr_d0h = sfr_wr && sfr_hit(sfr_sector, sfr_addr, OFS_DW0_HI);

  // operation starts; erase and write refuse unless unlocked
  assign start_prog  = wt_r && en_flag_r && mode_r == MODE_WRITE;
  assign start_erase = wt_r && en_flag_r && mode_r == MODE_ERASE;
  assign start_read  = rd_r && rden_r && mode_r == MODE_READ;
  assign drop_wt     = state_r == ST_IDLE && wt_r && !start_prog
                       && !start_erase;
  assign drop_rd     = state_r == ST_IDLE && rd_r && !start_read
                       && !start_prog && !start_erase;
  assign read_done   = state_r == ST_READ && fl_done;

  // a high-byte write is a load only while unlocked
  assign buf_we    = wr_d0h && en_flag_r;
  assign unlock_ok = trig_r && mode_r == MODE_UNLOCK &&
                     {dhi_r[1], dlo_r[1]} == UNLOCK_PAT1 &&
                     {dhi_r[2], dlo_r[2]} == UNLOCK_PAT2 &&
                     {dhi_r[3], dlo_r[3]} == UNLOCK_PAT3;
  assign op_done   = (state_r == ST_ERASE && fl_done) ||
                     (state_r == ST_PROG_WAIT && fl_done &&
                      pidx_r == OFS_W'(PAGE_WORDS - 1));
  // clear after a finished page write or on request
  assign buf_clr   = buffer_clear_bit_r ||
                     (state_r == ST_PROG_WAIT && fl_done &&
                      pidx_r == OFS_W'(PAGE_WORDS - 1));

  iapfc_wbuf #(
    .WIDTH (WORD_W),
    .DEPTH (PAGE_WORDS)
  ) u_wbuf (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clr     (buf_clr),
    .wr_en   (buf_we),
    .wr_idx  (addr_r[OFS_W-1:0]),
    .wr_data ({sfr_wdata, dlo_r[0]}),
    .rd_idx  (pidx_r),
    .rd_data (buf_rd)
  );

  // operation sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_prog) begin
          state_nxt = ST_PROG_REQ;
        end else if (start_erase) begin
          state_nxt = ST_ERASE;
        end else if (start_read) begin
          state_nxt = ST_READ;
        end
      end
      ST_ERASE: begin
        if (fl_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PROG_REQ: begin
        state_nxt = ST_PROG_WAIT;
      end
      ST_PROG_WAIT: begin
        if (fl_done) begin
          state_nxt = (pidx_r == OFS_W'(PAGE_WORDS - 1)) ? ST_IDLE
                                                         : ST_PROG_REQ;
        end
      end
      ST_READ: begin
        if (fl_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // word index walks all 64 buffer words during a page write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pidx_r <= '0;
    end else if (state_r == ST_IDLE) begin
      pidx_r <= '0;
    end else if (state_r == ST_PROG_WAIT && fl_done) begin
      pidx_r <= pidx_r + 1'b1;
    end
  end

  // flash macro command, registered so the macro sees clean levels
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fl_req_r   <= 1'b0;
      fl_op_r    <= FOP_NONE;
      fl_addr_r  <= ADDR_RST;
      fl_wdata_r <= WORD_RST;
    end else begin
      fl_req_r <= 1'b0;
      if (state_r == ST_IDLE && start_prog) begin
        fl_op_r <= FOP_PROG;
      end else if (state_r == ST_IDLE && start_erase) begin
        fl_req_r  <= 1'b1;
        fl_op_r   <= FOP_ERASE;
        fl_addr_r <= {addr_r[ADDR_W-1:OFS_W], OFS_W'(0)};
      end else if (state_r == ST_IDLE && start_read) begin
        fl_req_r  <= 1'b1;
        fl_op_r   <= FOP_READ;
        fl_addr_r <= addr_r;
      end else if (state_r == ST_PROG_REQ) begin
        fl_req_r   <= 1'b1;
        fl_addr_r  <= {addr_r[ADDR_W-1:OFS_W], pidx_r};
        fl_wdata_r <= buf_rd;
      end
    end
  end

  // the core waits on this for the whole operation
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpu_stall_r <= 1'b0;
    end else begin
      cpu_stall_r <= state_nxt != ST_IDLE;
    end
  end

  // flash_op_control; hardware set of the enable flag beats a clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_flag_r <= 1'b0;
      mode_r    <= MODE_WRITE;
      trig_r    <= 1'b0;
      wt_r      <= 1'b0;
      rden_r    <= 1'b0;
      rd_r      <= 1'b0;
    end else begin
      if (wr_op) begin
        mode_r <= sfr_wdata[FC_MODE_LSB +: 3];
        rden_r <= sfr_wdata[FC_RDEN_BIT];
        wt_r   <= sfr_wdata[FC_WT_BIT];
        rd_r   <= sfr_wdata[FC_RD_BIT];
        trig_r <= sfr_wdata[FC_TRIG_BIT];
        if (!sfr_wdata[FC_EN_BIT]) begin
          en_flag_r <= 1'b0;
        end
      end
      if (trig_r && unl_cnt_r == 16'h0001) begin
        trig_r <= 1'b0;
      end
      if (op_done || drop_wt) begin
        wt_r <= 1'b0;
      end
      if (read_done || drop_rd) begin
        rd_r <= 1'b0;
      end
      if (unlock_ok) begin
        en_flag_r <= 1'b1;
      end
    end
  end

  // unlock window timer, armed by the rising trigger bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unl_cnt_r <= 16'h0000;
    end else if (wr_op && sfr_wdata[FC_TRIG_BIT] && !trig_r) begin
      unl_cnt_r <= 16'(UNLOCK_CYCLES);
    end else if (trig_r && unl_cnt_r != 16'h0000) begin
      unl_cnt_r <= unl_cnt_r - 16'h0001;
    end
  end

  // buffer clear completes in the cycle after it is requested
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buffer_clear_bit_r <= 1'b0;
    end else if (buffer_clear_bit_r) begin
      buffer_clear_bit_r <= 1'b0;
    end else if (wr_clr) begin
      buffer_clear_bit_r <= sfr_wdata[BUFFER_CLEAR_BIT_BIT];
    end
  end

  // chip reset pattern; the reset request is a single-cycle pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstpat_r     <= REG_RST;
      chip_reset_r <= 1'b0;
    end else begin
      chip_reset_r <= wr_rst && sfr_wdata == CHIP_RESET_KEY;
      if (wr_rst) begin
        rstpat_r <= sfr_wdata;
      end
    end
  end

  // address pair; a load increments but never leaves the page
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= ADDR_RST;
    end else if (wr_alo) begin
      addr_r[7:0] <= sfr_wdata;
    end else if (wr_ahi) begin
      addr_r[ADDR_W-1:8] <= sfr_wdata[ADDR_W-9:0];
    end else if (buf_we && addr_r[OFS_W-1:0] != '1) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  // data pairs; a finished read lands in the first pair
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DPAIRS; i++) begin
        dlo_r[i] <= REG_RST;
        dhi_r[i] <= REG_RST;
      end
    end else begin
      for (int i = 0; i < DPAIRS; i++) begin
        if (sfr_wr && sfr_hit(sfr_sector, sfr_addr, dw_ofs(i, 1'b0))) begin
          dlo_r[i] <= sfr_wdata;
        end
        if (sfr_wr && sfr_hit(sfr_sector, sfr_addr, dw_ofs(i, 1'b1))) begin
          dhi_r[i] <= sfr_wdata;
        end
      end
      if (read_done) begin
        {dhi_r[0], dlo_r[0]} <= fl_rdata;
      end
    end
  end

  // register read port, one cycle of latency; unmapped reads give zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sfr_hit(sfr_sector, sfr_addr, OFS_OP_CTRL)) begin
      rd_mux = {en_flag_r, mode_r, trig_r, wt_r, rden_r, rd_r};
    end else if (sfr_hit(sfr_sector, sfr_addr, OFS_CHIP_RST)) begin
      rd_mux = rstpat_r;
    end else if (sfr_hit(sfr_sector, sfr_addr, OFS_BUF_CLR)) begin
      rd_mux = {7'h00, buffer_clear_bit_r};
    end else if (sfr_hit(sfr_sector, sfr_addr, OFS_ADDR_LO)) begin
      rd_mux = addr_r[7:0];
    end else if (sfr_hit(sfr_sector, sfr_addr, OFS_ADDR_HI)) begin
      rd_mux = {2'b00, addr_r[ADDR_W-1:8]};
    end else begin
      for (int i = 0; i < DPAIRS; i++) begin
        if (sfr_hit(sfr_sector, sfr_addr, dw_ofs(i, 1'b0))) begin
          rd_mux = dlo_r[i];
        end
        if (sfr_hit(sfr_sector, sfr_addr, dw_ofs(i, 1'b1))) begin
          rd_mux = dhi_r[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_r <= rd_mux;
    end
  end

  // checks
  a_load_increments: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (buf_we && addr_r[OFS_W-1:0] != '1) |=> addr_r == $past(addr_r) + 1'b1)
    else $error("address did not step after a buffer load");

  a_load_saturates: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (buf_we && addr_r[OFS_W-1:0] == '1) |=> $stable(addr_r))
    else $error("address left the page at its last word");

  a_load_blocked: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (wr_d0h && !en_flag_r && !wr_alo && !wr_ahi) |=> $stable(addr_r))
    else $error("load acted while erase/write disabled");

  a_unlock_sets: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    unlock_ok |=> en_flag_r)
    else $error("enable flag not set after unlock");

  a_write_busy: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_PROG_REQ) |-> wt_r ##1 (wt_r && cpu_stall_r))
    else $error("write-initiate bit fell during programming");

  a_page_clears: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_PROG_WAIT && fl_done && pidx_r == OFS_W'(PAGE_WORDS - 1))
    |-> buf_clr ##1 (!wt_r && state_r == ST_IDLE))
    else $error("page write end did not clear buffer and busy");

  a_read_result: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    read_done |=> (!rd_r && {dhi_r[0], dlo_r[0]} == $past(fl_rdata)))
    else $error("read result or initiate bit wrong");

  a_chip_reset: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (wr_rst && sfr_wdata == CHIP_RESET_KEY) |=> chip_reset_r ##1 !chip_reset_r)
    else $error("chip reset pulse missing");

  a_erase_page: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_IDLE && start_erase) |=>
    (fl_req_r && fl_op_r == FOP_ERASE && fl_addr_r[OFS_W-1:0] == '0))
    else $error("erase not issued on a page boundary");

  a_unlock_timeout: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (trig_r && unl_cnt_r == 16'h0001 && !wr_op) |=> !trig_r)
    else $error("unlock trigger survived its timeout");

endmodule
`default_nettype wire

//--- hdl/iapfc_pkg.sv
// constants, field layout and codes of the in-application flash controller
package iapfc_pkg;

  // timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int UNLOCK_TIME_NS = 64000;
  localparam int UNLOCK_CYC     = UNLOCK_TIME_NS / CLK_PERIOD_NS;

  // geometry
  localparam int PAGE_WORDS = 64;
  localparam int OFS_W      = 6;
  localparam int PAGE_W     = 8;
  localparam int ADDR_W     = 14;
  localparam int WORD_W     = 16;
  localparam int DPAIRS     = 4;

  // the controller answers in data memory sector 1 only
  localparam logic [2:0] IAP_SECTOR = 3'h1;

  // register offsets inside the sector
  localparam logic [7:0] OFS_OP_CTRL   = 8'h40;
  localparam logic [7:0] OFS_CHIP_RST  = 8'h41;
  localparam logic [7:0] OFS_BUF_CLR   = 8'h42;
  localparam logic [7:0] OFS_ADDR_LO   = 8'h43;
  localparam logic [7:0] OFS_ADDR_HI   = 8'h44;
  localparam logic [7:0] OFS_DW0_LO    = 8'h45;
  localparam logic [7:0] OFS_DW0_HI    = 8'h46;

  // flash_op_control and buffer-clear field positions
  localparam int FC_EN_BIT   = 7;
  localparam int FC_MODE_LSB = 4;
  localparam int FC_TRIG_BIT = 3;
  localparam int FC_WT_BIT   = 2;
  localparam int FC_RDEN_BIT = 1;
  localparam int FC_RD_BIT   = 0;
  localparam int BUFFER_CLEAR_BIT_BIT    = 0;

  // reset values
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [13:0] ADDR_RST  = 14'h0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  // value written to chip_reset_pattern that resets the chip
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;

  typedef enum logic [2:0] {
    MODE_WRITE  = 3'b000,
    MODE_ERASE  = 3'b001,
    MODE_READ   = 3'b011,
    MODE_UNLOCK = 3'b110
  } iapfc_mode_t;

  typedef enum logic [1:0] {
    FOP_NONE  = 2'b00,
    FOP_READ  = 2'b01,
    FOP_PROG  = 2'b10,
    FOP_ERASE = 2'b11
  } iapfc_fop_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ERASE     = 3'b001,
    ST_PROG_REQ  = 3'b010,
    ST_PROG_WAIT = 3'b011,
    ST_READ      = 3'b100
  } iapfc_state_t;

endpackage

//--- hdl/iapfc_wbuf.sv
// page write buffer: flip-flop storage with single-cycle whole clear
`timescale 1ns/100ps
`default_nettype none
module iapfc_wbuf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     clr,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("iapfc_wbuf: DEPTH must be a power of two >= 2");
    end
  endgenerate

  localparam int IDX_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // clear wins over a load so a clear leaves no stale word behind
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_word
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          mem_r[gi] <= '0;
        end else if (clr) begin
          mem_r[gi] <= '0;
        end else if (wr_en && wr_idx == IDX_W'(gi)) begin
          mem_r[gi] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = mem_r[rd_idx];

endmodule
`default_nettype wire
